// ===== cmac_mode_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module cmac_mode_ctrl
  import cmac_pkg::*;
#(
  parameter int RUN_LEN  = RECESSIVE_RUN,
  parameter int RUN_REPS = BUSOFF_RUNS
) (
  // Clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // AXI4-Lite slave
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Protocol core status
  input  wire logic        rx_busy,
  input  wire logic        tx_busy,
  input  wire logic        bus_off,
  input  wire logic        bit_tick,
  input  wire logic        core_tx,
  input  wire logic [3:0]  rx_tx_state,
  input  wire logic        hit_valid,
  input  wire logic [2:0]  hit_index,
  // CPU power modes
  input  wire logic        cpu_stop,
  input  wire logic        cpu_wait,
  // Bus pins
  input  wire logic        can_rx_pin,
  output logic             transmit_pin,
  // Core control
  output logic             core_abort,
  output logic             bus_synced,
  output logic             accept_enable
);
  cmac_mode_t  mode_q;
  logic [7:0]  ctl0_q, ctl1_q, btr0_q, btr1_q, idac_q, rflg_q;
  logic [7:0]  gen_q [GEN_N];
  logic [7:0]  code_q [8];
  logic [7:0]  mask_q [8];
  logic        wr_rdy_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic        rx_meta_q, rx_sync_q, rx_prev_q;
  logic        tx_pin_q, abort_q, synced_q, acc_en_q;
  logic [3:0]  run_q;
  logic [7:0]  reps_q;
  logic        we, in_init, init_entry, wake_ev, sleep_ack, init_ack;
  logic [7:0]  wa, wd;

  function automatic logic map_ok(input logic [7:0] a);
    map_ok = (a[1:0] == 2'h0) && (a < (OFS_GEN + 8'(4 * GEN_N)) ||
             (a >= OFS_CODE && a < OFS_MASK + 8'h20));
  endfunction

  assign wa         = awaddr;
  assign wd         = wdata[7:0];
  assign we         = ce && wr_rdy_q && wstrb[0] && map_ok(wa);
  assign sleep_ack  = (mode_q == MD_SLEEP);
  assign init_ack   = (mode_q == MD_INIT);
  assign in_init    = ctl0_q[BIT_INIT] && init_ack;
  assign init_entry = ctl0_q[BIT_INIT] && !init_ack;
  assign wake_ev    = sleep_ack && ctl0_q[BIT_WAKE] && rx_prev_q && !rx_sync_q;

  assign awready = wr_rdy_q;
  assign wready  = wr_rdy_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rresp   = rresp_q;
  assign rdata   = rdata_q;
  assign transmit_pin  = tx_pin_q;
  assign core_abort    = abort_q;
  assign bus_synced    = synced_q;
  assign accept_enable = acc_en_q;

  // Write channel: address and data taken together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_rdy_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (ce) begin
      wr_rdy_q <= awvalid && wvalid && !wr_rdy_q && !bvalid_q;
      if (wr_rdy_q) begin
        bvalid_q <= 1'b1;
        bresp_q  <= map_ok(wa) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= 32'h0;
    end else if (ce) begin
      arready_q <= arvalid && !arready_q && !rvalid_q;
      if (arready_q) begin
        rvalid_q <= 1'b1;
        rresp_q  <= map_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
        rdata_q  <= 32'h0;
        if (!map_ok(araddr))
          rdata_q[7:0] <= 8'h00;
        else if (araddr >= OFS_MASK)
          rdata_q[7:0] <= mask_q[araddr[4:2]];
        else if (araddr >= OFS_CODE)
          rdata_q[7:0] <= code_q[araddr[4:2]];
        else if (araddr >= OFS_GEN)
          rdata_q[7:0] <= gen_q[3'(araddr[7:2] - OFS_GEN[7:2])];
        else
          unique case (araddr)
            OFS_CTL0: rdata_q[7:0] <= ctl0_q;
            OFS_CTL1: rdata_q[7:0] <= {ctl1_q[7:2], sleep_ack, init_ack};
            OFS_BTR0: rdata_q[7:0] <= btr0_q;
            OFS_BTR1: rdata_q[7:0] <= btr1_q;
            OFS_IDAC: rdata_q[7:0] <= idac_q;
            OFS_RFLG: rdata_q[7:0] <= rflg_q;
            default:  rdata_q[7:0] <= 8'h00;
          endcase
      end else if (rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Mode sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= MD_RUN;
    end else if (ce) begin
      unique case (mode_q)
        MD_RUN:
          if (ctl0_q[BIT_INIT])
            mode_q <= MD_INIT;
          else if (ctl0_q[BIT_SLEEP] && !rx_busy && !tx_busy)
            mode_q <= MD_SLEEP;
        MD_SLEEP:
          if (ctl0_q[BIT_INIT])
            mode_q <= MD_INIT;
          else if (!ctl0_q[BIT_SLEEP])
            mode_q <= MD_RUN;
        MD_INIT:
          if (!ctl0_q[BIT_INIT])
            mode_q <= MD_RUN;
        default: mode_q <= MD_RUN;
      endcase
    end
  end

  // Control register zero and request handshakes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl0_q <= RST_ZERO;
    end else if (ce) begin
      if (we && wa == OFS_CTL0) begin
        ctl0_q[7:BIT_WAKE] <= wd[7:BIT_WAKE];
        if (wd[BIT_INIT] || in_init)
          ctl0_q[BIT_INIT] <= wd[BIT_INIT];
        if (wd[BIT_SLEEP] && !rflg_q[BIT_WFLAG])
          ctl0_q[BIT_SLEEP] <= 1'b1;
        else if (!wd[BIT_SLEEP] && ctl0_q[BIT_SLEEP] && sleep_ack)
          ctl0_q[BIT_SLEEP] <= 1'b0;
      end
      if (wake_ev)
        ctl0_q[BIT_SLEEP] <= 1'b0;
      if (init_entry)
        ctl0_q[7:3] <= RST_ZERO[7:3];
    end
  end

  // Init-protected configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl1_q <= RST_ZERO;
      btr0_q <= RST_BTR;
      btr1_q <= RST_BTR;
      idac_q <= RST_ZERO;
      for (int i = 0; i < 8; i++) begin
        code_q[i] <= RST_ZERO;
        mask_q[i] <= RST_ZERO;
      end
    end else if (ce) begin
      if (we && in_init) begin
        if (wa == OFS_CTL1) ctl1_q[7:2] <= wd[7:2];
        if (wa == OFS_BTR0) btr0_q <= wd;
        if (wa == OFS_BTR1) btr1_q <= wd;
        if (wa == OFS_IDAC) idac_q[BIT_AM+1:BIT_AM] <= wd[BIT_AM+1:BIT_AM];
        if (wa >= OFS_CODE && wa < OFS_MASK) code_q[wa[4:2]] <= wd;
        if (wa >= OFS_MASK) mask_q[wa[4:2]] <= wd;
      end
      if (hit_valid && idac_q[BIT_AM+1:BIT_AM] != AM_CLOSED)
        idac_q[2:0] <= hit_index;
    end
  end

  // Flag and enable registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rflg_q <= RST_ZERO;
      for (int i = 0; i < GEN_N; i++)
        gen_q[i] <= (i == GEN_TFLG) ? RST_TFLG : RST_ZERO;
    end else if (ce) begin
      rflg_q[5:2] <= rx_tx_state;
      if (we && wa == OFS_RFLG && wd[BIT_WFLAG])
        rflg_q[BIT_WFLAG] <= 1'b0;
      if (we && wa >= OFS_GEN && wa < OFS_CODE)
        gen_q[3'(wa[7:2] - OFS_GEN[7:2])] <= wd;
      if (init_entry) begin
        rflg_q[BIT_WFLAG] <= 1'b0;
        for (int i = 0; i < GEN_N; i++)
          gen_q[i] <= (i == GEN_TFLG) ? RST_TFLG : RST_ZERO;
      end
      if (wake_ev)
        rflg_q[BIT_WFLAG] <= 1'b1;
    end
  end

  // Receive pin synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else if (ce) begin
      rx_meta_q <= can_rx_pin;
      rx_sync_q <= rx_meta_q;
      rx_prev_q <= rx_sync_q;
    end
  end

  // Bus integration after init
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      synced_q <= 1'b0;
      run_q    <= 4'h0;
      reps_q   <= 8'h0;
      abort_q  <= 1'b0;
    end else if (ce) begin
      abort_q <= init_entry;
      if (ctl0_q[BIT_INIT]) begin
        synced_q <= 1'b0;
        run_q    <= 4'h0;
        reps_q   <= 8'h0;
      end else if (bit_tick && !synced_q) begin
        if (!rx_sync_q) begin
          run_q <= 4'h0;
        end else if (run_q == 4'(RUN_LEN - 1)) begin
          run_q <= 4'h0;
          if (!bus_off || reps_q == 8'(RUN_REPS - 1))
            synced_q <= 1'b1;
          else
            reps_q <= reps_q + 8'h1;
        end else begin
          run_q <= run_q + 4'h1;
        end
      end
    end
  end

  // Transmit pin and acceptance enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_pin_q <= 1'b1;
      acc_en_q <= 1'b0;
    end else if (ce) begin
      tx_pin_q <= (ctl0_q[BIT_INIT] || cpu_stop || (cpu_wait && ctl0_q[BIT_SIW]))
                  ? 1'b1 : core_tx;
      acc_en_q <= idac_q[BIT_AM+1:BIT_AM] != AM_CLOSED;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sleep_idle_a: assert property ($rose(sleep_ack) |-> $past(!rx_busy && !tx_busy))
    else $error("sleep entered while bus busy");
  sleep_ack_a: assert property (ce && mode_q == MD_RUN && ctl0_q[BIT_SLEEP] && !ctl0_q[BIT_INIT]
                                && !rx_busy && !tx_busy |=> sleep_ack)
    else $error("idle sleep request not acknowledged");
  sleep_block_a: assert property (ce && we && wa == OFS_CTL0 && rflg_q[BIT_WFLAG] && !ctl0_q[BIT_SLEEP]
                                  |=> !ctl0_q[BIT_SLEEP])
    else $error("sleep request set with wake flag");
  wake_clear_a: assert property (ce && wake_ev |=> !ctl0_q[BIT_SLEEP] && rflg_q[BIT_WFLAG])
    else $error("wake did not end sleep");
  sleep_hold_a: assert property ($fell(ctl0_q[BIT_SLEEP]) && !$past(wake_ev) |-> $past(sleep_ack))
    else $error("sleep request cleared early");
  init_enter_a: assert property (ce && init_entry |=> init_ack && abort_q ##1 !abort_q || !$past(ce))
    else $error("init not acknowledged");
  init_hold_a: assert property ($fell(ctl0_q[BIT_INIT]) |-> $past(init_ack))
    else $error("init request cleared early");
  init_reset_a: assert property (ce && init_entry |=> gen_q[GEN_TFLG] == RST_TFLG && ctl0_q[7:3] == 5'h0)
    else $error("init entry did not reset");
  tx_force_a: assert property (ce && ctl0_q[BIT_INIT] |=> transmit_pin)
    else $error("transmit pin not recessive");
  stop_force_a: assert property (ce && (cpu_stop || (cpu_wait && ctl0_q[BIT_SIW])) |=> transmit_pin)
    else $error("transmit pin driven in stop");
  resync_a: assert property ($rose(synced_q) |-> $past(!ctl0_q[BIT_INIT] && rx_sync_q && bit_tick))
    else $error("sync without recessive run");
  closed_hit_a: assert property (idac_q[5:4] == AM_CLOSED |=> $stable(idac_q[2:0]))
    else $error("hit updated in closed mode");

  sleep_c: cover property ($rose(sleep_ack));
  init_c: cover property ($rose(init_ack));
  wake_c: cover property (wake_ev);
  sync_c: cover property ($rose(synced_q) && bus_off);
endmodule
`default_nettype wire

// ===== cmac_pkg.sv
// Notes on behaviour
// - Sleep entered only when bus idle
// - Sleep entry shown by sleep_acknowledge high
// - Sleep request cannot set while wake flag set
// - Sleep ends by CPU clear or bus wake
// - Sleep request clear blocked until sleep entered
// - Init request aborts traffic, drops bus sync
// - Init entry shown by init_acknowledge high
// - Init entry resets listed registers, keeps states
// - Config registers writable only in init mode
// - Resync after init: 11 recessive, bus-off 128x
// - Init request clear blocked until init entered
// - Transmit pin recessive on init request
// - Transmit pin recessive in stop, wait-stop
// - Acceptance mode field selects filter organisation
// - Closed filter accepts no message
// - Read-only three-bit filter hit index
package cmac_pkg;
  localparam logic [7:0] OFS_CTL0  = 8'h00;
  localparam logic [7:0] OFS_CTL1  = 8'h04;
  localparam logic [7:0] OFS_BTR0  = 8'h08;
  localparam logic [7:0] OFS_BTR1  = 8'h0c;
  localparam logic [7:0] OFS_IDAC  = 8'h10;
  localparam logic [7:0] OFS_RFLG  = 8'h14;
  localparam logic [7:0] OFS_GEN   = 8'h18;
  localparam logic [7:0] OFS_CODE  = 8'h40;
  localparam logic [7:0] OFS_MASK  = 8'h60;
  localparam int         GEN_N     = 6;
  localparam int         GEN_TFLG  = 1;
  localparam int         BIT_INIT  = 0;
  localparam int         BIT_SLEEP = 1;
  localparam int         BIT_WAKE  = 2;
  localparam int         BIT_SIW   = 5;
  localparam int         BIT_WFLAG = 7;
  localparam int         BIT_AM    = 4;
  localparam logic [1:0] AM_CLOSED = 2'h3;
  localparam logic [7:0] RST_ZERO  = 8'h00;
  localparam logic [7:0] RST_TFLG  = 8'h07;
  localparam logic [7:0] RST_BTR   = 8'h00;
  localparam int         RECESSIVE_RUN = 11;
  localparam int         BUSOFF_RUNS   = 128;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    MD_RUN   = 2'h0,
    MD_SLEEP = 2'h1,
    MD_INIT  = 2'h3
  } cmac_mode_t;
endpackage

// ===== cmac_can_bus.sv
`timescale 1ns/1ps
`default_nettype none
module cmac_can_bus (
  // Clock
  input  wire logic aclk,
  // Node drives
  input  wire logic tx,
  input  wire logic dominant,
  // Line and bit timing
  output logic      rx,
  output logic      tick
);
  logic [1:0] cnt_q = 2'h0;
  logic       rx_q  = 1'b1;
  logic       tk_q  = 1'b0;
  // Wired-and line: any dominant node pulls it low
  always @(posedge aclk) begin
    cnt_q <= cnt_q + 2'h1;
    tk_q  <= (cnt_q == 2'h3);
    rx_q  <= tx & ~dominant;
  end
  assign rx   = rx_q;
  assign tick = tk_q;
endmodule
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cmac_pkg::*;
  logic        aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
  logic        rx_busy, tx_busy, bus_off, core_tx, hit_valid, cpu_stop, cpu_wait, dom;
  logic        awready, wready, bvalid, arready, rvalid, bit_tick, can_rx_pin;
  logic        transmit_pin, core_abort, bus_synced, accept_enable;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb, rx_tx_state;
  logic [2:0]  hit_index;
  logic [1:0]  bresp, rresp, rs;
  int          num_errors, samples_checked;

  cmac_mode_ctrl #(.RUN_LEN(3), .RUN_REPS(4)) DUT (
    .aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .rx_busy, .tx_busy, .bus_off, .bit_tick,
    .core_tx, .rx_tx_state, .hit_valid, .hit_index, .cpu_stop, .cpu_wait,
    .can_rx_pin, .transmit_pin, .core_abort, .bus_synced, .accept_enable
  );
  cmac_can_bus BUS (.aclk, .tx(transmit_pin), .dominant(dom), .rx(can_rx_pin), .tick(bit_tick));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    while (bvalid !== 1'b1) @(posedge aclk);
    rs = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task rdr(input logic [7:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task ticks(input int n);
    repeat (n) do @(posedge aclk); while (bit_tick !== 1'b1);
  endtask

  task t_init;
    rdr(8'h3c);
    chk(rs, RESP_SLVERR);
    chk(rd, 32'h0);
    wr(8'h3c, 8'h00);
    chk(rs, RESP_SLVERR);
    wr(OFS_CTL0, 8'h01);
    chk(core_abort, 1);
    rdr(OFS_CTL1);
    chk(rd[0], 1);
    chk(bus_synced, 0);
    wr(OFS_BTR0, 8'h5a);
    chk(rs, RESP_OKAY);
    wr(OFS_CTL0, 8'h00);
    ticks(2);
    chk(bus_synced, 0);
    ticks(4);
    chk(bus_synced, 1);
    rdr(OFS_CTL1);
    chk(rd[0], 0);
    wr(OFS_BTR0, 8'h33);
    rdr(OFS_BTR0);
    chk(rd, 32'h5a);
    wr(OFS_CTL0, 8'h01);
    bus_off <= 1'b1;
    wr(OFS_CTL0, 8'h00);
    ticks(9);
    chk(bus_synced, 0);
    ticks(6);
    chk(bus_synced, 1);
    bus_off <= 1'b0;
    $display("init test done");
  endtask

  task t_tx;
    ce      <= 1'b0;
    core_tx <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(transmit_pin, 1);
    ce      <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(transmit_pin, 0);
    cpu_stop <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(transmit_pin, 1);
    cpu_stop <= 1'b0;
    cpu_wait <= 1'b1;
    wr(OFS_CTL0, 8'h20);
    chk(transmit_pin, 1);
    cpu_wait <= 1'b0;
    wr(OFS_CTL0, 8'h01);
    chk(transmit_pin, 1);
    core_tx <= 1'b1;
    wr(OFS_CTL0, 8'h00);
    ticks(6);
    $display("pin test done");
  endtask

  task t_sleep;
    rx_tx_state <= 4'ha;
    tx_busy     <= 1'b1;
    rx_busy     <= 1'b1;
    wr(OFS_CTL0, 8'h02);
    rdr(OFS_CTL1);
    chk(rd[1], 0);
    wr(OFS_CTL0, 8'h00);
    rdr(OFS_CTL0);
    chk(rd[1], 1);
    tx_busy <= 1'b0;
    rdr(OFS_CTL1);
    chk(rd[1], 0);
    rx_busy <= 1'b0;
    rdr(OFS_CTL1);
    chk(rd[1], 1);
    wr(OFS_CTL0, 8'h00);
    rdr(OFS_CTL1);
    chk(rd[1], 0);
    wr(OFS_GEN, 8'h80);
    rdr(OFS_GEN);
    chk(rd, 32'h80);
    wr(OFS_CTL0, 8'h06);
    dom <= 1'b1;
    repeat (4) @(posedge aclk);
    dom <= 1'b0;
    rdr(OFS_CTL0);
    chk(rd[1], 0);
    rdr(OFS_RFLG);
    chk(rd[7], 1);
    wr(OFS_CTL0, 8'h06);
    rdr(OFS_CTL0);
    chk(rd[1], 0);
    wr(OFS_RFLG, 8'h80);
    wr(OFS_CTL0, 8'h02);
    wr(OFS_CTL0, 8'h03);
    rdr(OFS_CTL1);
    chk(rd[1:0], 2'h1);
    rdr(OFS_GEN);
    chk(rd, 32'h0);
    rdr(OFS_GEN + 8'h04);
    chk(rd, {24'h0, RST_TFLG});
    rdr(OFS_RFLG);
    chk(rd[5:2], 4'ha);
    wr(OFS_CTL0, 8'h00);
    wr(OFS_CTL0, 8'h00);
    rdr(OFS_CTL0);
    chk(rd[1:0], 2'h0);
    $display("sleep test done");
  endtask

  task t_accept;
    for (int m = 0; m < 4; m++) begin
      wr(OFS_CTL0, 8'h01);
      wr(OFS_IDAC, 8'(m << 4));
      rdr(OFS_IDAC);
      chk(rd[5:4], m);
      wr(OFS_CTL0, 8'h00);
      ticks(6);
      chk(accept_enable, m != 3);
    end
    hit_index <= 3'h5;
    hit_valid <= 1'b1;
    @(posedge aclk);
    hit_valid <= 1'b0;
    rdr(OFS_IDAC);
    chk(rd[2:0], 0);
    wr(OFS_CTL0, 8'h01);
    wr(OFS_IDAC, 8'h10);
    wr(OFS_CTL0, 8'h00);
    for (int i = 0; i < 8; i++) begin
      hit_index <= 3'(i);
      hit_valid <= 1'b1;
      @(posedge aclk);
      hit_valid <= 1'b0;
      rdr(OFS_IDAC);
      chk(rd[2:0], i);
    end
    $display("acceptance test done");
  endtask

  task end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, rx_busy, tx_busy} = 8'h00;
    {bus_off, hit_valid, cpu_stop, cpu_wait, dom} = 5'h00;
    core_tx = 1'b1;
    ce      = 1'b1;
    {awaddr, araddr, wdata, wstrb, rx_tx_state, hit_index} = {16'h0, 32'h0, 4'hf, 4'h0, 3'h0};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_init;
    t_tx;
    t_sleep;
    t_accept;
    end_of_test;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    end_of_test;
  end
endmodule
`default_nettype wire
